// *** ecl_cfg.svh ***
// Constants of the configuration field loader: register offsets, EEPROM word
// addresses, field positions and reset values. Included by the package users.
`ifndef ECL_CFG_SVH
`define ECL_CFG_SVH

// Per-port configuration register offsets (low byte of the bus address)
`define ECL_OFS_PM_CTRL 8'h70
`define ECL_OFS_PHY_PARAM0 8'h74
`define ECL_OFS_PHY_PARAM1 8'h78
`define ECL_OFS_PHY_PARAM2 8'h7C
`define ECL_OFS_TL_CTRL 8'h8C
`define ECL_OFS_PHY_PARAM3 8'h90
`define ECL_OFS_TX_MARGIN 8'h94
`define ECL_OFS_DEV_CAP 8'hC4
`define ECL_OFS_LINK_CAP 8'hCC
`define ECL_OFS_DEV_CAP2 8'hE4

// Block-level registers (byte addresses)
`define ECL_ADDR_STATUS 12'h400
`define ECL_ADDR_CONTROL 12'h404

// EEPROM word addresses that carry configuration fields
`define ECL_EE_W_CAPS 8'h0C
`define ECL_EE_W_MARGIN 8'h0E
`define ECL_EE_W_NOM_DRIVE 8'h10
`define ECL_EE_W_POST_EMPH 8'h12
`define ECL_EE_W_PHY_TIMING 8'h14
`define ECL_EE_W_STEP 8'h02

// Field positions inside the target registers
`define ECL_DEVCAP_MPS_LSB 0
`define ECL_DEVCAP_RBER_BIT 15
`define ECL_LINKCAP_ASPM_LSB 10
`define ECL_LINKCAP_SDOWN_BIT 19
`define ECL_LINKCAP_BWN_BIT 21
`define ECL_PM_MSI_DIS_BIT 14
`define ECL_PM_PMCAP_DIS_BIT 13
`define ECL_P0_PARITY_DIS_BIT 15
`define ECL_P0_NOM_DRIVE_LSB 16
`define ECL_P1_POST_EMPH_LSB 16
`define ECL_P2_TX_LAT_LSB 0
`define ECL_P2_RX_DET_LSB 4
`define ECL_P3_HALF_DELTA_LSB 15
`define ECL_TL_SOF_LAT_BIT 0
`define ECL_TL_DSEL_RW_BIT 1
`define ECL_TL_4KB_CHK_BIT 3
`define ECL_TL_PASS_NP_BIT 5
`define ECL_TL_ORD_FREEZE_BIT 6
`define ECL_TL_PHYIF0_BIT 16
`define ECL_TL_PHYIF_HI_LSB 17
`define ECL_TL_GEN2_BIT 31
`define ECL_MARGIN_LSB 0
`define ECL_DEVCAP2_LTR_BIT 12
`define ECL_DEVCAP2_OBFF_BIT 18

// Reset value and bus response codes
`define ECL_REG_RESET 32'h0000_0000
`define ECL_RESP_OKAY 2'b00
`define ECL_RESP_SLVERR 2'b10

`endif

// *** ecl_pkg.sv ***
// Types shared by the configuration field loader modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ecl_pkg;

	typedef enum logic [3:0] {
		REG_PM_CTRL,
		REG_PHY_PARAM0,
		REG_PHY_PARAM1,
		REG_PHY_PARAM2,
		REG_TL_CTRL,
		REG_PHY_PARAM3,
		REG_TX_MARGIN,
		REG_DEV_CAP,
		REG_LINK_CAP,
		REG_DEV_CAP2
	} ecl_reg_t;

	typedef enum logic [1:0] {
		FS_IDLE,
		FS_REQ,
		FS_ABSENT
	} ecl_fetch_state_t;

endpackage

// *** ecl_word_fetch.sv ***
// Word fetch sequencer: walks the EEPROM configuration words in order.
// Assumes a serial EEPROM engine on the same clock answering word requests.
`timescale 1ns/1ns
`include "ecl_cfg.svh"

module ecl_word_fetch import ecl_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control
	input wire logic start,
	output logic busy,
	output logic absent,
	// EEPROM word port
	output logic ee_req,
	output logic [7:0] ee_addr,
	input wire logic ee_ack,
	input wire logic [15:0] ee_data,
	input wire logic ee_present,
	// Fetched word
	output logic word_valid,
	output logic [7:0] word_addr,
	output logic [15:0] word_data
);

	ecl_fetch_state_t state, next_state;
	logic [7:0] next_ee_addr;
	logic next_word_valid;
	logic [7:0] next_word_addr;
	logic [15:0] next_word_data;

	always_comb begin
		next_state = state;
		next_ee_addr = ee_addr;
		next_word_valid = 1'b0;
		next_word_addr = word_addr;
		next_word_data = word_data;
		case (state)
			FS_IDLE, FS_ABSENT: begin
				if (start) begin
					// Without a valid EEPROM the reset defaults stay [R24]
					next_state = ee_present ? FS_REQ : FS_ABSENT;
					next_ee_addr = `ECL_EE_W_CAPS;
				end
			end
			FS_REQ: begin
				if (ee_ack) begin
					next_word_valid = 1'b1;
					next_word_addr = ee_addr;
					next_word_data = ee_data;
					if (ee_addr == `ECL_EE_W_PHY_TIMING) begin
						next_state = FS_IDLE;
					end else begin
						next_ee_addr = ee_addr + `ECL_EE_W_STEP;
					end
				end
			end
			default: begin
				next_state = FS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= FS_IDLE;
			ee_addr <= 8'h00;
			word_valid <= 1'b0;
			word_addr <= 8'h00;
			word_data <= 16'h0000;
		end else begin
			state <= next_state;
			ee_addr <= next_ee_addr;
			word_valid <= next_word_valid;
			word_addr <= next_word_addr;
			word_data <= next_word_data;
		end
	end

	assign ee_req = (state == FS_REQ);
	// Last word is still being merged one cycle after the final ack
	assign busy = (state == FS_REQ) || word_valid;
	assign absent = (state == FS_ABSENT);

endmodule

// *** ecl_config_loader.sv ***
// Configuration field loader: copies EEPROM words into per-port configuration
// registers after reset and serves the registers over AXI4-Lite.
// Assumes an EEPROM engine on sys_clk that returns one 16-bit word per request.
//
// Behaviour
// R1: EEPROM word 0Ch bits 1:0 go to payload size support, C4h bits 1:0.
// R2: Word 0Ch bits 3:2 go to link power support, CCh bits 11:10.
// R3: Word 0Ch bit 4 goes to role-based error reporting, C4h bit 15.
// R4: Word 0Ch bit 5 goes to 70h bit 14, removing MSI capability.
// R5: Word 0Ch bit 6 goes to 74h bit 15, disabling compliance parity.
// R6: Word 0Ch bit 7 goes to 70h bit 13, disabling power management capability.
// R7: Word 0Ch bit 8 goes to 8Ch bit 5, posted passing non-posted.
// R8: Word 0Ch bit 9 goes to CCh bit 21, ports 1 and 2 only.
// R9: Word 0Ch bit 10 goes to 8Ch bit 6, freezing packet ordering.
// R10: Word 0Ch bit 11 goes to 8Ch bit 0; zero shortens frame latency.
// R11: Word 0Ch bit 12 goes to CCh bit 19, surprise-down reporting.
// R12: Word 0Ch bit 13 goes to 8Ch bit 1, data select writable.
// R13: Word 0Ch bit 14 goes to E4h bit 12, latency reporting capability.
// R14: Word 0Ch bit 15 goes to 8Ch bit 3, 4KB boundary check.
// R15: Word 0Eh bits 14:0 go unchanged to 94h bits 14:0, margin drive levels.
// R16: Word 0Eh bit 15 goes to E4h bit 18, buffer flush capability.
// R17: Word 10h bits 14:0 go to 74h bits 30:16, nominal drive levels.
// R18: Word 10h bit 15 goes to 8Ch bit 31, second generation mode.
// R19: Word 12h bits 14:0 go to 78h bits 30:16, post-cursor emphasis.
// R20: Word 12h bit 15 goes to 8Ch bit 16, PHY interface control.
// R21: Word 14h bits 3:0 transmit latency, bits 6:4 receiver detect, 7Ch.
// R22: Word 14h bits 11:7 go to 90h bits 19:15, half-swing delta.
// R23: Word 14h bits 15:12 go to 8Ch bits 20:17.
// R24: Loads finish before host access; no EEPROM leaves reset defaults.
`timescale 1ns/1ns
`include "ecl_cfg.svh"

module ecl_config_loader import ecl_pkg::*; #(
	parameter int NUM_PORTS = 4,
	parameter int LOADED_PORTS = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// EEPROM word port
	output logic ee_req,
	output logic [7:0] ee_addr,
	input wire logic ee_ack,
	input wire logic [15:0] ee_data,
	input wire logic ee_present,
	// Load status
	output logic load_done
);

	localparam int NUM_REGS = 10;

	// Register store
	logic [31:0] cfg [0:NUM_PORTS-1][0:NUM_REGS-1];
	logic [31:0] next_cfg [0:NUM_PORTS-1][0:NUM_REGS-1];

	// Load sequencing
	logic start_pending, next_start_pending;
	logic reload, next_reload;
	logic fetch_busy;
	logic fetch_absent;
	logic word_valid;
	logic [7:0] word_addr;
	logic [15:0] word_data;
	logic [2:0] words_loaded, next_words_loaded;

	// Write channel state
	logic aw_held, next_aw_held;
	logic [11:0] aw_addr_q, next_aw_addr_q;
	logic w_held, next_w_held;
	logic [31:0] w_data_q, next_w_data_q;
	logic [3:0] w_strb_q, next_w_strb_q;
	logic next_bvalid;
	logic [1:0] next_bresp;

	// Read channel state
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	logic do_write;
	logic [31:0] byte_mask;
	logic [4:0] wr_hit;
	logic [4:0] rd_hit;
	logic [31:0] status_word;

	// Bit 4 flags a mapped offset, bits 3:0 give the register slot
	function automatic logic [4:0] reg_lookup(input logic [7:0] ofs);
		logic [4:0] r;
		r = 5'h00;
		case (ofs)
			`ECL_OFS_PM_CTRL: r = {1'b1, REG_PM_CTRL};
			`ECL_OFS_PHY_PARAM0: r = {1'b1, REG_PHY_PARAM0};
			`ECL_OFS_PHY_PARAM1: r = {1'b1, REG_PHY_PARAM1};
			`ECL_OFS_PHY_PARAM2: r = {1'b1, REG_PHY_PARAM2};
			`ECL_OFS_TL_CTRL: r = {1'b1, REG_TL_CTRL};
			`ECL_OFS_PHY_PARAM3: r = {1'b1, REG_PHY_PARAM3};
			`ECL_OFS_TX_MARGIN: r = {1'b1, REG_TX_MARGIN};
			`ECL_OFS_DEV_CAP: r = {1'b1, REG_DEV_CAP};
			`ECL_OFS_LINK_CAP: r = {1'b1, REG_LINK_CAP};
			`ECL_OFS_DEV_CAP2: r = {1'b1, REG_DEV_CAP2};
			default: r = 5'h00;
		endcase
		return r;
	endfunction

	ecl_word_fetch i_ecl_word_fetch (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(start_pending || reload),
		.busy(fetch_busy),
		.absent(fetch_absent),
		.ee_req(ee_req),
		.ee_addr(ee_addr),
		.ee_ack(ee_ack),
		.ee_data(ee_data),
		.ee_present(ee_present),
		.word_valid(word_valid),
		.word_addr(word_addr),
		.word_data(word_data)
	);

	// Bus stays stalled until every field is in place [R24]
	assign load_done = !(start_pending || reload || fetch_busy);

	assign s_axi_awready = load_done && !aw_held && !s_axi_bvalid;
	assign s_axi_wready = load_done && !w_held && !s_axi_bvalid;
	assign s_axi_arready = load_done && !s_axi_rvalid;

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = reg_lookup(aw_addr_q[7:0]);
	assign rd_hit = reg_lookup(s_axi_araddr[7:0]);
	assign byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign status_word = {27'h000_0000, words_loaded, fetch_absent, load_done};

	// Load sequencing
	always_comb begin
		next_start_pending = 1'b0;
		next_reload = 1'b0;
		next_words_loaded = words_loaded;
		if (start_pending || reload) begin
			next_words_loaded = 3'h0;
		end else if (word_valid) begin
			next_words_loaded = words_loaded + 3'h1;
		end
		// Reload request from software, ignored while a load runs
		if (do_write && aw_addr_q == `ECL_ADDR_CONTROL && w_strb_q[0] && w_data_q[0] && load_done) begin
			next_reload = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			start_pending <= 1'b1;
			reload <= 1'b0;
			words_loaded <= 3'h0;
		end else begin
			start_pending <= next_start_pending;
			reload <= next_reload;
			words_loaded <= next_words_loaded;
		end
	end

	// Register store: software writes and EEPROM field loads
	always_comb begin
		next_cfg = cfg;
		if (do_write && aw_addr_q[11:10] == 2'b00 && wr_hit[4]) begin
			next_cfg[aw_addr_q[9:8]][wr_hit[3:0]] =
				(cfg[aw_addr_q[9:8]][wr_hit[3:0]] & ~byte_mask) | (w_data_q & byte_mask);
		end
		// Bus is stalled while loading, so the two writers never meet
		if (word_valid) begin
			for (int p = 0; p < LOADED_PORTS; p++) begin
				case (word_addr)
					`ECL_EE_W_CAPS: begin
						next_cfg[p][REG_DEV_CAP][`ECL_DEVCAP_MPS_LSB +: 2] = word_data[1:0]; // [R1]
						next_cfg[p][REG_LINK_CAP][`ECL_LINKCAP_ASPM_LSB +: 2] = word_data[3:2]; // [R2]
						next_cfg[p][REG_DEV_CAP][`ECL_DEVCAP_RBER_BIT] = word_data[4]; // [R3]
						next_cfg[p][REG_PM_CTRL][`ECL_PM_MSI_DIS_BIT] = word_data[5]; // [R4]
						next_cfg[p][REG_PHY_PARAM0][`ECL_P0_PARITY_DIS_BIT] = word_data[6]; // [R5]
						next_cfg[p][REG_PM_CTRL][`ECL_PM_PMCAP_DIS_BIT] = word_data[7]; // [R6]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_PASS_NP_BIT] = word_data[8]; // [R7]
						// Port 0 is upstream and keeps its default
						if (p == 1 || p == 2) begin
							next_cfg[p][REG_LINK_CAP][`ECL_LINKCAP_BWN_BIT] = word_data[9]; // [R8]
						end
						next_cfg[p][REG_TL_CTRL][`ECL_TL_ORD_FREEZE_BIT] = word_data[10]; // [R9]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_SOF_LAT_BIT] = word_data[11]; // [R10]
						next_cfg[p][REG_LINK_CAP][`ECL_LINKCAP_SDOWN_BIT] = word_data[12]; // [R11]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_DSEL_RW_BIT] = word_data[13]; // [R12]
						next_cfg[p][REG_DEV_CAP2][`ECL_DEVCAP2_LTR_BIT] = word_data[14]; // [R13]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_4KB_CHK_BIT] = word_data[15]; // [R14]
					end
					`ECL_EE_W_MARGIN: begin
						next_cfg[p][REG_TX_MARGIN][`ECL_MARGIN_LSB +: 15] = word_data[14:0]; // [R15]
						next_cfg[p][REG_DEV_CAP2][`ECL_DEVCAP2_OBFF_BIT] = word_data[15]; // [R16]
					end
					`ECL_EE_W_NOM_DRIVE: begin
						next_cfg[p][REG_PHY_PARAM0][`ECL_P0_NOM_DRIVE_LSB +: 15] = word_data[14:0]; // [R17]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_GEN2_BIT] = word_data[15]; // [R18]
					end
					`ECL_EE_W_POST_EMPH: begin
						next_cfg[p][REG_PHY_PARAM1][`ECL_P1_POST_EMPH_LSB +: 15] = word_data[14:0]; // [R19]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_PHYIF0_BIT] = word_data[15]; // [R20]
					end
					`ECL_EE_W_PHY_TIMING: begin
						next_cfg[p][REG_PHY_PARAM2][`ECL_P2_TX_LAT_LSB +: 4] = word_data[3:0]; // [R21]
						next_cfg[p][REG_PHY_PARAM2][`ECL_P2_RX_DET_LSB +: 3] = word_data[6:4]; // [R21]
						next_cfg[p][REG_PHY_PARAM3][`ECL_P3_HALF_DELTA_LSB +: 5] = word_data[11:7]; // [R22]
						next_cfg[p][REG_TL_CTRL][`ECL_TL_PHYIF_HI_LSB +: 4] = word_data[15:12]; // [R23]
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int r = 0; r < NUM_REGS; r++) begin
					cfg[p][r] <= `ECL_REG_RESET;
				end
			end
		end else begin
			cfg <= next_cfg;
		end
	end

	// Write channel: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr_q = aw_addr_q;
		next_w_held = w_held;
		next_w_data_q = w_data_q;
		next_w_strb_q = w_strb_q;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr_q = {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data_q = s_axi_wdata;
			next_w_strb_q = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			// Status is read-only; a write there is answered with an error
			if ((aw_addr_q[11:10] == 2'b00 && wr_hit[4]) || aw_addr_q == `ECL_ADDR_CONTROL) begin
				next_bresp = `ECL_RESP_OKAY;
			end else begin
				next_bresp = `ECL_RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ECL_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr_q <= next_aw_addr_q;
			w_held <= next_w_held;
			w_data_q <= next_w_data_q;
			w_strb_q <= next_w_strb_q;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `ECL_RESP_OKAY;
			if (s_axi_araddr[11:10] == 2'b00 && rd_hit[4]) begin
				next_rdata = cfg[s_axi_araddr[9:8]][rd_hit[3:0]];
			end else if ({s_axi_araddr[11:2], 2'b00} == `ECL_ADDR_STATUS) begin
				next_rdata = status_word;
			end else if ({s_axi_araddr[11:2], 2'b00} == `ECL_ADDR_CONTROL) begin
				// Reload bit clears itself
				next_rdata = 32'h0000_0000;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = `ECL_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ECL_RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

endmodule

// *** ecl_config_loader_properties.sv ***
// Port-level checks of the configuration field loader.
// Assumes binding into ecl_config_loader; one clock, async active-low reset.
`timescale 1ns/1ns

module ecl_config_loader_properties #(
	parameter int NUM_PORTS = 4,
	parameter int LOADED_PORTS = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// EEPROM side
	input wire logic ee_req,
	input wire logic [7:0] ee_addr,
	input wire logic ee_ack,
	input wire logic load_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_stall_loading: assert property (!load_done |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("bus ready while loading");
	a_req_in_load: assert property (ee_req |-> !load_done)
		else $error("word request outside a load");
	a_req_stands: assert property (ee_req && !ee_ack |=> ee_req && $stable(ee_addr))
		else $error("word request dropped or moved before ack");
	a_word_step: assert property (ee_req && ee_ack && ee_addr != 8'h14 |=> ee_addr == $past(ee_addr) + 8'h02)
		else $error("word address did not advance by two");
	a_load_finish: assert property (ee_req && ee_ack && ee_addr == 8'h14 |=> !load_done ##1 load_done)
		else $error("load not done two edges after last word");
	a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write response after address and data");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after read address");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule

bind ecl_config_loader ecl_config_loader_properties #(.NUM_PORTS(NUM_PORTS), .LOADED_PORTS(LOADED_PORTS)) i_props (
	.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ee_req, .ee_addr, .ee_ack, .load_done);

// *** ecl_eeprom_model.sv ***
// Behavioural EEPROM word engine holding the five configuration words.
// Assumes requests held until ack; lag sets the answer delay in cycles.
`timescale 1ns/1ns

module ecl_eeprom_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bench control
	input wire logic present,
	input wire logic [3:0] lag,
	input wire logic [79:0] words,
	// Word port
	input wire logic ee_req,
	input wire logic [7:0] ee_addr,
	output logic ee_ack,
	output logic [15:0] ee_data,
	output logic ee_present
);
	logic [3:0] wait_cnt;
	int idx;

	assign ee_present = present;
	assign idx = (int'(ee_addr) - 12) / 2;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_cnt <= 4'h0;
			ee_ack <= 1'b0;
			ee_data <= 16'h0000;
		end else if (ee_req && !ee_ack && wait_cnt >= lag) begin
			ee_ack <= 1'b1;
			wait_cnt <= 4'h0;
			ee_data <= (idx >= 0 && idx < 5) ? words[idx*16 +: 16] : 16'h0000;
		end else begin
			// Data not held outside the ack cycle
			ee_ack <= 1'b0;
			ee_data <= ~ee_data;
			wait_cnt <= ee_req ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// *** ecl_config_loader_tb.sv ***
// Self-checking bench of the configuration field loader.
// Assumes the EEPROM model and the bound property checker.
`timescale 1ns/1ns

module ecl_config_loader_tb;
	localparam logic [79:0] W = 80'h3C5A_96E1_B4D2_7F08_A5C3;
	typedef struct {logic [11:0] addr; logic [31:0] exp;} ecl_row_t;
	logic sys_clk = 0, reset_n = 0, present = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, lag = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic ee_req, ee_ack, ee_present, load_done;
	logic [7:0] ee_addr;
	logic [15:0] ee_data;
	logic [79:0] words = 0;
	logic [7:0] ofs [10] = '{8'h70, 8'h74, 8'h78, 8'h7C, 8'h8C, 8'h90, 8'h94, 8'hC4, 8'hCC, 8'hE4};
	ecl_row_t rows [40];
	int mismatches = 0, n_compared = 0, cycles = 0;

	ecl_config_loader i_ecl_config_loader (.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ee_req, .ee_addr, .ee_ack, .ee_data,
		.ee_present, .load_done);
	ecl_eeprom_model i_ecl_eeprom_model (.sys_clk, .reset_n, .present, .lag, .words, .ee_req,
		.ee_addr, .ee_ack, .ee_data, .ee_present);

	initial forever #2 sys_clk = ~sys_clk;

	task final_report;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			final_report();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Ready is sampled mid-cycle; inputs only move at rising edges
	task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
		logic ta, tw, aw, dw, got;
		aw = 0;
		dw = 0;
		s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1; s_axi_wdata <= v;
		while (!(aw && dw)) begin
			@(negedge sys_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge sys_clk);
			if (ta) begin s_axi_awvalid <= 0; aw = 1; end
			if (tw) begin s_axi_wvalid <= 0; dw = 1; end
		end
		// Late bready lets the checker see the response held
		repeat (2) @(posedge sys_clk);
		s_axi_bready <= 1;
		do begin
			@(negedge sys_clk);
			got = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge sys_clk);
		end while (!got);
		s_axi_bready <= 0;
	endtask

	task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
		logic ta, got;
		s_axi_arvalid <= 1; s_axi_araddr <= a;
		do begin
			@(negedge sys_clk);
			ta = s_axi_arvalid && s_axi_arready;
			@(posedge sys_clk);
		end while (!ta);
		s_axi_arvalid <= 0;
		// Late rready lets the checker see read data held
		@(posedge sys_clk);
		s_axi_rready <= 1;
		do begin
			@(negedge sys_clk);
			got = s_axi_rvalid;
			v = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge sys_clk);
		end while (!got);
		s_axi_rready <= 0;
	endtask

	function automatic logic [31:0] expv(int p, logic [7:0] o, logic [79:0] w);
		logic [15:0] c, m, n, e, t;
		{t, e, n, m, c} = w;
		expv = 32'h0000_0000;
		// Port 3 is never loaded
		if (p < 3) case (o)
			8'h70: expv = 32'(c[5]) << 14 | 32'(c[7]) << 13;
			8'h74: expv = 32'(c[6]) << 15 | 32'(n[14:0]) << 16;
			8'h78: expv = 32'(e[14:0]) << 16;
			8'h7C: expv = 32'(t[6:0]);
			8'h8C: expv = {n[15], 10'h000, t[15:12], e[15], 9'h000, c[10], c[8], 1'b0, c[15], 1'b0, c[13], c[11]};
			8'h90: expv = 32'(t[11:7]) << 15;
			8'h94: expv = 32'(m[14:0]);
			8'hC4: expv = 32'(c[4]) << 15 | 32'(c[1:0]);
			8'hCC: expv = 32'(c[3:2]) << 10 | 32'(c[12]) << 19 | (p > 0 ? 32'(c[9]) << 21 : 32'h0000_0000);
			8'hE4: expv = 32'(c[14]) << 12 | 32'(m[15]) << 18;
			default: expv = 32'h0000_0000;
		endcase
	endfunction

	task run_rows(input logic [79:0] w);
		for (int i = 0; i < 40; i++)
			rows[i] = '{12'(i / 10 * 256) | 12'(ofs[i % 10]), expv(i / 10, ofs[i % 10], w)};
		for (int i = 0; i < 40; i++) begin
			rd(rows[i].addr, d, r);
			chk(d, rows[i].exp);
			chk(32'(r), 32'h0000_0000);
		end
	endtask

	task do_reset(input logic p, input logic [3:0] l, input logic [79:0] w);
		reset_n <= 0; present <= p; lag <= l; words <= w;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1;
		@(negedge sys_clk);
		chk(32'(load_done), 32'h0000_0000);
		@(posedge sys_clk);
	endtask

	initial begin
		// No EEPROM: every field keeps its reset value
		do_reset(0, 4'h0, 80'h0);
		run_rows(80'h0);
		rd(12'h400, d, r);
		chk(d, 32'h0000_0003);
		// Slow EEPROM, then a fast reload with every bit inverted
		do_reset(1, 4'h3, W);
		run_rows(W);
		rd(12'h400, d, r);
		chk(d, 32'h0000_0015);
		words <= ~W; lag <= 4'h0;
		wr(12'h404, 32'h0000_0001, r);
		chk(32'(r), 32'h0000_0000);
		run_rows(~W);
		// Software access, then refused places
		wr(12'h38C, 32'h1234_5678, r);
		chk(32'(r), 32'h0000_0000);
		rd(12'h38C, d, r);
		chk(d, 32'h1234_5678);
		wr(12'h098, 32'hFFFF_FFFF, r);
		chk(32'(r), 32'h0000_0002);
		rd(12'h098, d, r);
		chk({d[29:0], r}, 32'h0000_0002);
		wr(12'h400, 32'hFFFF_FFFF, r);
		chk(32'(r), 32'h0000_0002);
		final_report();
	end
endmodule
